// file: rtl/dsu_consts.vh
// constants for the service unit erase, security and identification block
// assumes inclusion by bare name from rtl and testbench files
`ifndef DSU_CONSTS_VH
`define DSU_CONSTS_VH
// register word offsets (byte address within one 0x100 copy, id base 0xFD0 above the copies)
`define DSU_OFF_CTRL 12'h000
`define DSU_OFF_STATUSA 12'h004
`define DSU_OFF_STATUSB 12'h008
`define DSU_OFF_DEVID 12'h018
`define DSU_OFF_CFG 12'h01C
`define DSU_OFF_PIDBASE 12'hFD0
`define DSU_OFF_ROMBASE 12'h01C
`define DSU_PID_SPAN 12'h020
// address windows
`define DSU_EXT_BASE 14'h0100
`define DSU_EXT_END 14'h2000
`define DSU_COPY_SIZE 14'h0100
// ctrl bits
`define DSU_CTRL_CE 1
// statusa bits
`define DSU_STA_DONE 0
`define DSU_STA_CRST 1
`define DSU_STA_PERR 3
// statusb bits
`define DSU_STB_PROT 0
`define DSU_STB_DBGPRES 1
`define DSU_STB_HPE 4
// cfg bits
`define DSU_CFG_GUARD 0
// erase phase lengths in cycles of the block clock
`define DSU_VOL_CYCLES 8'd16
`define DSU_FLASH_CYCLES 8'd64
`define DSU_LOCK_CYCLES 8'd8
// identification defaults (arbitrary neutral values)
`define DSU_MFG_CODE 7'h2A
`define DSU_PART_CODE 12'h5A5
`define DSU_REVISION 4'h0
`define DSU_DEVID_VALUE 32'h10010305
`define DSU_ROM_BASE 32'h41003000
`endif

// file: rtl/dsu_sync2.v
// two flip-flop synchroniser for one level from outside the clock domain
// assumes clk is the block clock
`timescale 1ns/1ps
module dsu_sync2 (
  input wire clk,
  input wire rst,
  input wire rst_val,
  input wire d,
  output reg q
);
  reg meta;
  // first stage read only by second stage
  always @(posedge clk) begin
    if (rst) begin
      // both stages start at the level the caller calls idle
      meta <= rst_val;
      q <= rst_val;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: rtl/dsu_erase_seq.v
// erase sequencer: volatile clear, flash array erase, lock row erase
// assumes one-cycle start pulse and memory strobes sampled by the memories
`timescale 1ns/1ps
`include "dsu_consts.vh"
module dsu_erase_seq (
  input wire clk,
  input wire rst,
  input wire start,
  output reg busy,
  output reg done_pulse,
  output reg vol_clear,
  output reg flash_erase,
  output reg lock_erase
);
  localparam ST_IDLE = 2'b00;
  localparam ST_VOL = 2'b01;
  localparam ST_FLASH = 2'b10;
  localparam ST_LOCK = 2'b11;
  reg [1:0] state;
  reg [7:0] count;
  // phase sequencing, each phase a fixed count
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      count <= 8'h00;
      busy <= 1'b0;
      done_pulse <= 1'b0;
      vol_clear <= 1'b0;
      flash_erase <= 1'b0;
      lock_erase <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_VOL;
            count <= `DSU_VOL_CYCLES - 8'd1;
            busy <= 1'b1;
            vol_clear <= 1'b1;
          end
        end
        ST_VOL: begin
          if (count == 8'h00) begin
            state <= ST_FLASH;
            count <= `DSU_FLASH_CYCLES - 8'd1;
            vol_clear <= 1'b0;
            flash_erase <= 1'b1;
          end else begin
            count <= count - 8'd1;
          end
        end
        ST_FLASH: begin
          if (count == 8'h00) begin
            state <= ST_LOCK;
            count <= `DSU_LOCK_CYCLES - 8'd1;
            flash_erase <= 1'b0;
            lock_erase <= 1'b1;
          end else begin
            count <= count - 8'd1;
          end
        end
        ST_LOCK: begin
          if (count == 8'h00) begin
            state <= ST_IDLE;
            lock_erase <= 1'b0;
            busy <= 1'b0;
            done_pulse <= 1'b1;
          end else begin
            count <= count - 8'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// file: rtl/dsu_core.v
// service unit core: chip erase, protection filter, reset extension, identification
// assumes apb master on clk, protection level and strap pins from outside the domain
//
// Summary of operation
// - chip erase wipes volatile memory and flash array, not auxiliary rows
// - writing one to the erase bit in control starts a chip erase
// - erase command ignored while the write guard protects the registers
// - erase clears volatile memory, then flash array, then the lock row
// - completion flag in status A set when erase finishes, reads as one
// - memory programming through debug port only while unprotected
// - external reset low keeps internal resets and slow clocks
// - swclk low at reset release holds cpu, rest of system runs
// - protected debugger accesses outside external range get error response
// - low 0x100 bytes serve cpu, mirror at 0x100 serves debugger
// - protected debugger transfers accepted only in 0x0100 to 0x2000
// - protected: refuse cpu hold clear and disable hot-plug detection
// - lockout allows nonvolatile writes only from on-chip code
// - expose 64-bit peripheral id over eight id registers
// - revision field zero means use device id register
// - device id register encodes processor, family, series, select
// - rom table base readable from access port base register
// - reset release with swclk low detects debugger and holds cpu
// - writing one to cpu hold flag releases cpu unless protected
// - commands discarded while an operation runs
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "dsu_consts.vh"
module dsu_core (
  input wire clk,
  input wire rst,
  input wire ext_reset_n,
  input wire swclk,
  input wire security_bit,
  input wire lockout,
  input wire debug_master,
  input wire cpu_nvm_write,
  input wire dbg_nvm_write,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output reg cpu_reset_hold,
  output reg sys_reset_hold,
  output reg slow_clock_sel,
  output reg vol_clear,
  output reg flash_erase,
  output reg lock_erase,
  output reg nvm_write_allow,
  output reg debugger_present
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // swclk starts at its pulled-up idle level, so leaving block reset
  // never looks like a falling edge or a cold plug
  // the reset pin starts as asserted, so a pin already low keeps the
  // internal resets on with no one-cycle gap after block reset
  wire swclk_s;
  wire ext_rst_n_s;

  dsu_sync2 u_sync_clk (
    .clk(clk),
    .rst(rst),
    .rst_val(1'b1),
    .d(swclk),
    .q(swclk_s)
  );

  dsu_sync2 u_sync_rst (
    .clk(clk),
    .rst(rst),
    .rst_val(1'b0),
    .d(ext_reset_n),
    .q(ext_rst_n_s)
  );
  reg prot_m;
  reg prot;
  reg lock_m;
  reg lock_s;
  // protection levels from fuse domain
  // protection reads as set until the fuse level has passed both stages,
  // the safe side while the real state is unknown
  always @(posedge clk) begin
    if (rst) begin
      prot_m <= 1'b1;
      prot <= 1'b1;
      lock_m <= 1'b0;
      lock_s <= 1'b0;
    end else begin
      prot_m <= security_bit;
      prot <= prot_m;
      lock_m <= lockout;
      lock_s <= lock_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode helpers
  // is_ext: debugger window, the mirror copy up to 0x2000
  // reg_off: both 0x100 copies fold onto one register offset,
  // anything above them (identification words) keeps its own offset
  function is_ext;
    input [13:0] a;
    begin
      is_ext = (a >= `DSU_EXT_BASE) && (a < `DSU_EXT_END);
    end
  endfunction
  function [11:0] reg_off;
    input [13:0] a;
    begin
      if (a < `DSU_COPY_SIZE)
        reg_off = {4'h0, a[7:0]};
      else if (a < (`DSU_COPY_SIZE + `DSU_COPY_SIZE))
        reg_off = {4'h0, a[7:0]};
      else
        reg_off = a[11:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb access qualification
  // one wait state per transfer: first access cycle registers read data
  // and error, second cycle presents them with pready
  // hazard avoided: a tied-high ready would hand over stale data,
  // since read data and error come from flip-flops
  reg guard;
  reg resp_ready;
  wire access = psel && penable;
  wire ext_acc = debug_master;

  // protected debugger access outside window refused
  wire filt_err = ext_acc && prot && !is_ext(paddr);
  wire [11:0] off = reg_off(paddr);

  // writes land only at the completing edge, once per transfer
  wire wr_ok = access && resp_ready && pwrite && !filt_err;
  wire rd_ok = access && !pwrite && !filt_err;

  // write guard binds cpu writes only, never the debugger
  wire guard_block = !ext_acc && guard;
  assign pready = resp_ready;

  ////////////////////////////////////////////////////////////////////////
  // control and status state
  reg done_flag;
  reg perr_flag;
  reg hot_seen;
  reg swclk_d;
  reg rst_d;
  wire seq_busy;
  wire seq_done;
  wire seq_vol;
  wire seq_flash;
  wire seq_lock;
  wire ce_write = wr_ok && (off == `DSU_OFF_CTRL) && pstrb[0] && pwdata[`DSU_CTRL_CE];
  wire ce_start = ce_write && !guard_block && !seq_busy;
  wire rst_rise = ext_rst_n_s && !rst_d;
  wire crst_wr = wr_ok && (off == `DSU_OFF_STATUSA) && pstrb[0] && pwdata[`DSU_STA_CRST];
  wire perr_wr = wr_ok && (off == `DSU_OFF_STATUSA) && pstrb[0] && pwdata[`DSU_STA_PERR];
  wire done_wr = wr_ok && (off == `DSU_OFF_STATUSA) && pstrb[0] && pwdata[`DSU_STA_DONE];

  dsu_erase_seq u_seq (
    .clk(clk),
    .rst(rst),
    .start(ce_start),
    .busy(seq_busy),
    .done_pulse(seq_done),
    .vol_clear(seq_vol),
    .flash_erase(seq_flash),
    .lock_erase(seq_lock)
  );

  // edge trackers for reset release and swclk falling
  // both read only the second synchroniser stage, reset to idle levels
  // so no false edge follows block reset
  always @(posedge clk) begin
    if (rst) begin
      swclk_d <= 1'b1;
      rst_d <= 1'b0;
    end else begin
      swclk_d <= swclk_s;
      rst_d <= ext_rst_n_s;
    end
  end

  // reset extension, debugger detection, status flags
  // the cpu stays in reset while the pin does; at release the level
  // of swclk decides whether the hold is extended for a debugger
  always @(posedge clk) begin
    if (rst) begin
      cpu_reset_hold <= 1'b1;
      debugger_present <= 1'b0;
      hot_seen <= 1'b0;
      done_flag <= 1'b0;
      perr_flag <= 1'b0;
      guard <= 1'b0;
    end else begin
      if (!ext_rst_n_s) begin
        cpu_reset_hold <= 1'b1;
        hot_seen <= 1'b0;
        debugger_present <= 1'b0;
      end else if (rst_rise) begin
        // swclk low: cold plug, hold cpu; swclk high: plain restart
        cpu_reset_hold <= !swclk_s;
        debugger_present <= !swclk_s;
      end else if (crst_wr) begin
        if (prot)
          perr_flag <= 1'b1;
        else
          cpu_reset_hold <= 1'b0;
      end else if (rst_d && swclk_d && !swclk_s && !prot) begin
        hot_seen <= 1'b1;
        debugger_present <= 1'b1;
      end
      if (perr_wr && !(crst_wr && prot))
        perr_flag <= 1'b0;
      // set wins over clear on completion
      if (seq_done)
        done_flag <= 1'b1;
      else if (ce_start || done_wr)
        done_flag <= 1'b0;
      if (wr_ok && (off == `DSU_OFF_CFG) && pstrb[0] && !ext_acc)
        guard <= pwdata[`DSU_CFG_GUARD];
    end
  end

  // reset, clock and erase strobes to the system
  // slow clock select holds from reset pin low until its release
  // erase strobes are one register behind the sequencer phases
  always @(posedge clk) begin
    if (rst) begin
      sys_reset_hold <= 1'b1;
      slow_clock_sel <= 1'b1;
      vol_clear <= 1'b0;
      flash_erase <= 1'b0;
      lock_erase <= 1'b0;
      nvm_write_allow <= 1'b0;
    end else begin
      sys_reset_hold <= !ext_rst_n_s;
      slow_clock_sel <= !ext_rst_n_s ? 1'b1 : slow_clock_sel & ~rst_rise;
      vol_clear <= seq_vol;
      flash_erase <= seq_flash;
      lock_erase <= seq_lock;
      // debug writes need unprotected, unlocked; cpu writes always ok
      nvm_write_allow <= cpu_nvm_write || (dbg_nvm_write && !prot && !lock_s);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // identification words
  // eight words from the id base: ids 4 to 7 first, then ids 0 to 3
  // id 0: part number low byte
  // id 1: maker code low nibble, part number high nibble
  // id 2: revision, maker code in use, maker code high bits
  // id 3 to 7: unused fields, continuation code and size count, all zero
  localparam [6:0] MFG = `DSU_MFG_CODE;
  localparam [11:0] PART = `DSU_PART_CODE;
  localparam [3:0] REV = `DSU_REVISION;
  wire [11:0] pid_rel = off - `DSU_OFF_PIDBASE;
  wire pid_hit = (off >= `DSU_OFF_PIDBASE) && (off < (`DSU_OFF_PIDBASE + `DSU_PID_SPAN));

  function [7:0] pid_byte;
    input [2:0] idx;
    begin
      case (idx)
        3'd0: pid_byte = PART[7:0];
        3'd1: pid_byte = {MFG[3:0], PART[11:8]};
        3'd2: pid_byte = {REV, 1'b1, MFG[6:4]};
        3'd3: pid_byte = 8'h00;
        3'd4: pid_byte = 8'h00;
        default: pid_byte = 8'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // read data and error response
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h00000000;
    case (off)
      `DSU_OFF_STATUSA: next_prdata = {28'h0, perr_flag, 1'b0, cpu_reset_hold, done_flag};
      `DSU_OFF_STATUSB: next_prdata = {27'h0, hot_seen | !prot, 2'b00, debugger_present, prot};
      `DSU_OFF_DEVID: next_prdata = `DSU_DEVID_VALUE;
      `DSU_OFF_CFG: next_prdata = {31'h0, guard};
      default: begin
        if (pid_hit)
          next_prdata = {24'h0, pid_byte({~pid_rel[4], pid_rel[3:2]})};
      end
    endcase
    if (ext_acc && (off == `DSU_OFF_ROMBASE) && paddr >= `DSU_EXT_END)
      next_prdata = `DSU_ROM_BASE;
  end

  // response registers and the single wait state
  // resp_ready rises after the first access cycle, falls after the second
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      resp_ready <= 1'b0;
    end else begin
      resp_ready <= access && !resp_ready;
      prdata <= rd_ok ? next_prdata : 32'h00000000;
      pslverr <= access && filt_err;
    end
  end
endmodule

// file: testbench/dsu_core_chk.sv
// assertions on the service unit core ports
// assumes bind from the bench top file, one clock domain
`timescale 1ns/1ps
`include "dsu_consts.vh"
module dsu_core_chk (
  input wire clk,
  input wire rst,
  input wire ext_reset_n,
  input wire swclk,
  input wire security_bit,
  input wire lockout,
  input wire debug_master,
  input wire cpu_nvm_write,
  input wire dbg_nvm_write,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire cpu_reset_hold,
  input wire sys_reset_hold,
  input wire slow_clock_sel,
  input wire vol_clear,
  input wire flash_erase,
  input wire lock_erase,
  input wire nvm_write_allow,
  input wire debugger_present
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // completed transfer, debugger window, hold flag write
  wire acc = psel && penable && pready;
  wire in_win = paddr >= `DSU_EXT_BASE && paddr < `DSU_EXT_END;
  wire hold_wr = acc && pwrite && debug_master && paddr == 14'h0104 && pwdata[`DSU_STA_CRST];
  ////////////////////////////////////////////////////////////////
  AST_PHASE_EXCL: assert property ($onehot0({vol_clear, flash_erase, lock_erase}))
    else $error("erase phases overlap");
  AST_VOL_TO_FLASH: assert property ($fell(vol_clear) |-> ##[0:2] flash_erase)
    else $error("flash erase did not follow volatile clear");
  AST_FLASH_TO_LOCK: assert property ($fell(flash_erase) |-> ##[0:2] lock_erase)
    else $error("lock erase did not follow flash erase");
  AST_EXT_RESET_HOLD: assert property (!ext_reset_n [*4] |-> sys_reset_hold && slow_clock_sel && cpu_reset_hold)
    else $error("reset pin low without internal hold");
  AST_FILTER_ERR: assert property (acc && debug_master && security_bit && $past(security_bit, 4) && !in_win
    |-> pslverr)
    else $error("protected access outside window not refused");
  AST_FILTER_PASS: assert property (acc && debug_master && !pwrite && paddr >= 14'h0100 && paddr < 14'h0200
    |-> !pslverr)
    else $error("mirror read refused");
  AST_HOLD_REFUSED: assert property (hold_wr && security_bit && $past(security_bit, 4) && cpu_reset_hold
    |=> cpu_reset_hold [*2])
    else $error("protected hold release taken");
  AST_HOLD_RELEASE: assert property (hold_wr && !security_bit && !$past(security_bit, 4)
    |-> ##[1:3] !cpu_reset_hold)
    else $error("hold release ignored");
  AST_LOCKOUT: assert property ((lockout && dbg_nvm_write && !cpu_nvm_write) [*4] |-> !nvm_write_allow)
    else $error("probe write allowed under lockout");
  AST_PROT_NVM: assert property ((security_bit && dbg_nvm_write && !cpu_nvm_write) [*4] |-> !nvm_write_allow)
    else $error("probe write allowed while protected");
  AST_HOT_PROT: assert property ($rose(debugger_present) && security_bit |-> ##[0:2] cpu_reset_hold)
    else $error("protected detection without cpu hold");
  // main scenarios reached
  COV_ERASE: cover property ($rose(vol_clear));
  COV_LOCK: cover property ($fell(lock_erase));
  COV_REFUSE: cover property (acc && pslverr);
  COV_DETECT: cover property ($rose(debugger_present));
endmodule

// file: testbench/dsu_probe_model.sv
// debug probe model driving the reset pin and the serial clock
// assumes swclk idles high through the pad pull-up between frames
`timescale 1ns/1ps
module dsu_probe_model (
  output logic ext_reset_n,
  output logic swclk
);
  // power up with reset pin held low
  initial begin
    ext_reset_n = 1'h0;
    swclk = 1'h1;
  end
  // short link clock burst, ends at the idle level
  task burst;
    #3;
    repeat (8) begin
      #40 swclk = 1'h0;
      #40 swclk = 1'h1;
    end
  endtask
  // reset with swclk low, release, then clock the link
  task cold_plug;
    #3 swclk = 1'h0;
    ext_reset_n = 1'h0;
    #400 ext_reset_n = 1'h1;
    #200 burst;
  endtask
  // restart with swclk high so the cpu runs
  task warm_restart;
    #3 swclk = 1'h1;
    ext_reset_n = 1'h0;
    #400 ext_reset_n = 1'h1;
    #200;
  endtask
endmodule

// file: testbench/dsu_core_bench.sv
// self-checking bench for the service unit core
// assumes the probe model drives the reset pin and swclk
`timescale 1ns/1ps
`include "dsu_consts.vh"
module dsu_core_bench;
  logic clk, rst, security_bit, lockout, debug_master, cpu_nvm_write, dbg_nvm_write, psel, penable, pwrite, er;
  logic [13:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] pstrb;
  logic [31:0] pid [8];
  wire ext_reset_n, swclk, pready, pslverr, cpu_reset_hold, sys_reset_hold, slow_clock_sel;
  wire vol_clear, flash_erase, lock_erase, nvm_write_allow, debugger_present;
  wire [31:0] prdata;
  int err_total, total_checks, vc, fc, lc, ers, b0, b1, b2, b3;
  logic vp = 1'h0;
  localparam logic [13:0] CTL_X = 14'h0100;
  localparam logic [13:0] STA_X = 14'h0104;
  localparam logic [11:0] PN = `DSU_PART_CODE;
  localparam logic [6:0] MF = `DSU_MFG_CODE;
  dsu_core i_dsu_core (.*);
  dsu_probe_model i_dsu_probe_model (.ext_reset_n(ext_reset_n), .swclk(swclk));
  ////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // erase phase cycle counts and run starts
  always @(posedge clk) begin
    vc <= vc + vol_clear;
    fc <= fc + flash_erase;
    lc <= lc + lock_erase;
    ers <= ers + (vol_clear && !vp);
    vp <= vol_clear;
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer, result left in rd and er
  task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 40) begin
      chk(0, 1, "no ready");
      wrap_up;
    end
  endtask
  // poll the completion flag through the debugger copy
  task wait_done;
    int n;
    n = 0;
    do begin
      apb(1'h0, STA_X, 32'h0);
      n++;
    end while (rd[`DSU_STA_DONE] !== 1'h1 && n < 100);
    chk(rd[`DSU_STA_DONE], 1, "erase done");
    if (n >= 100) wrap_up;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'h1;
    {security_bit, lockout, cpu_nvm_write, dbg_nvm_write, psel, penable, pwrite} = 7'h0;
    debug_master = 1'h1;
    paddr = 14'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pid = '{32'h0, 32'h0, 32'h0, 32'h0, 32'(PN[7:0]), 32'({MF[3:0], PN[11:8]}),
      32'({`DSU_REVISION, 1'h1, MF[6:4]}), 32'h0};
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    i_dsu_probe_model.cold_plug;
    apb(1'h0, STA_X, 32'h0);
    chk(debugger_present, 1, "cold detect");
    chk({cpu_reset_hold, sys_reset_hold, slow_clock_sel}, 4, "cpu held, system free");
    chk(rd[`DSU_STA_CRST], 1, "hold flag");
    $display("test cold plug done");
    for (int k = 0; k < 8; k++) begin
      apb(1'h0, 14'h0FD0 + 14'(4 * k), 32'h0);
      chk(rd, pid[k], "peripheral id");
    end
    apb(1'h0, 14'h0118, 32'h0);
    chk(rd, `DSU_DEVID_VALUE, "device id");
    apb(1'h0, 14'h201C, 32'h0);
    chk(rd, `DSU_ROM_BASE, "rom table base");
    $display("test identification done");
    security_bit <= 1'h1;
    apb(1'h0, 14'h0004, 32'h0);
    chk(er, 1, "low copy refused");
    apb(1'h0, 14'h2000, 32'h0);
    chk(er, 1, "above window refused");
    apb(1'h1, STA_X, 32'h2);
    apb(1'h0, STA_X, 32'h0);
    chk(er, 0, "window allowed");
    chk({cpu_reset_hold, rd[`DSU_STA_PERR]}, 3, "release refused");
    $display("test protection done");
    b0 = ers;
    b1 = vc;
    b2 = fc;
    b3 = lc;
    apb(1'h1, CTL_X, 32'h2);
    apb(1'h1, CTL_X, 32'h2);
    wait_done;
    chk(ers - b0, 1, "one erase run");
    chk(vc - b1, 16, "volatile phase");
    chk(fc - b2, 64, "flash phase");
    chk(lc - b3, 8, "lock phase");
    security_bit <= 1'h0;
    apb(1'h1, CTL_X, 32'h2);
    apb(1'h0, STA_X, 32'h0);
    chk(rd[`DSU_STA_DONE], 0, "done cleared");
    wait_done;
    $display("test erase done");
    debug_master <= 1'h0;
    apb(1'h1, 14'h001C, 32'h1);
    b0 = ers;
    apb(1'h1, 14'h0000, 32'h2);
    repeat (20) @(posedge clk);
    chk(ers - b0, 0, "guarded erase ignored");
    apb(1'h1, 14'h001C, 32'h0);
    debug_master <= 1'h1;
    apb(1'h1, STA_X, 32'h2);
    apb(1'h0, STA_X, 32'h0);
    chk({cpu_reset_hold, rd[`DSU_STA_CRST]}, 0, "cpu released");
    $display("test guard and release done");
    lockout <= 1'h1;
    dbg_nvm_write <= 1'h1;
    repeat (4) @(posedge clk);
    chk(nvm_write_allow, 0, "lockout blocks probe");
    dbg_nvm_write <= 1'h0;
    cpu_nvm_write <= 1'h1;
    repeat (4) @(posedge clk);
    chk(nvm_write_allow, 1, "on-chip write");
    {lockout, cpu_nvm_write} <= 2'h0;
    {security_bit, dbg_nvm_write} <= 2'h3;
    repeat (4) @(posedge clk);
    chk(nvm_write_allow, 0, "protected probe write");
    dbg_nvm_write <= 1'h0;
    i_dsu_probe_model.warm_restart;
    @(posedge clk);
    chk(cpu_reset_hold, 0, "restart without hold");
    i_dsu_probe_model.burst;
    repeat (6) @(posedge clk);
    chk(debugger_present, 0, "no hot plug when protected");
    $display("test restart done");
    wrap_up;
  end
endmodule
bind dsu_core dsu_core_chk i_dsu_core_chk (.*);
